// ### pdsr_pkg.sv
// Shared constants, types and decode functions of the sink control block.
package pdsr_pkg;

  // Clock rate and indicator timing.
  localparam int CLK_MHZ = 250;
  localparam int BREATH_PERIOD_MS = 4000;
  localparam int MOIST_PERIOD_MS = 2000;
  localparam int FAULT_PERIOD_MS = 600;
  localparam int BREATH_CYC = BREATH_PERIOD_MS * CLK_MHZ * 1000;
  localparam int MOIST_CYC = MOIST_PERIOD_MS * CLK_MHZ * 1000;
  localparam int FAULT_CYC = FAULT_PERIOD_MS * CLK_MHZ * 1000;
  localparam int BREATH_STEPS = 512;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_REQUEST = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_PDO_BASE = 8'h40;
  localparam logic [7:0] OFS_PDO_LAST = 8'h5C;

  // Control register bits.
  localparam int CTRL_EVAL_START = 0;
  localparam int CTRL_NEG_ACCEPT = 1;
  localparam int CTRL_NON_PD = 2;
  localparam int CTRL_NEG_REJECT = 3;

  // Power object entry fields; currents in 10 mA, voltages in 100 mV.
  localparam int PDO_MAXI_LSB = 0;
  localparam int PDO_MAXV_LSB = 9;
  localparam int PDO_MINV_LSB = 18;
  localparam int PDO_ADJ_BIT = 27;
  localparam int PDO_EPR_BIT = 28;
  localparam int PDO_VALID_BIT = 31;
  localparam int PDO_COUNT = 8;

  // Interrupt bits.
  localparam int IRQ_EVAL_DONE = 0;
  localparam int IRQ_CHARGING = 1;
  localparam int IRQ_MISMATCH = 2;
  localparam int IRQ_MOISTURE = 3;
  localparam int IRQ_FAULT = 4;
  localparam int IRQ_WIDTH = 5;

  // Highest selection level that names a real voltage (index 6).
  localparam logic [2:0] VOLTAGE_SELECT_LAST_VALID = 3'h5;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_CHARGING,
    ST_MISMATCH,
    ST_MOISTURE,
    ST_FAULT
  } pdsr_state_e;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_SCAN,
    ENG_DONE
  } pdsr_eng_e;

  // Selection level 0..7 stands for index 1..8.
  function automatic logic [8:0] voltOfLevel(input logic [2:0] lvl);
    case (lvl)
      3'h0: voltOfLevel = 9'h032;
      3'h1: voltOfLevel = 9'h05A;
      3'h2: voltOfLevel = 9'h078;
      3'h3: voltOfLevel = 9'h096;
      3'h4: voltOfLevel = 9'h0C8;
      3'h5: voltOfLevel = 9'h118;
      default: voltOfLevel = 9'h000;
    endcase
  endfunction

  function automatic logic [8:0] currOfLevel(input logic [2:0] lvl);
    case (lvl)
      3'h0: currOfLevel = 9'h064;
      3'h1: currOfLevel = 9'h096;
      3'h2: currOfLevel = 9'h0C8;
      3'h3: currOfLevel = 9'h0FA;
      3'h4: currOfLevel = 9'h12C;
      3'h5: currOfLevel = 9'h15E;
      3'h6: currOfLevel = 9'h190;
      default: currOfLevel = 9'h1F4;
    endcase
  endfunction

endpackage

// ### pdsr_indicator.sv
// Indicator pattern generator for the sink status states.
`timescale 1ns/1ns
module pdsr_indicator #(
  parameter int BREATH_CYC = pdsr_pkg::BREATH_CYC,
  parameter int MOIST_CYC = pdsr_pkg::MOIST_CYC,
  parameter int FAULT_CYC = pdsr_pkg::FAULT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pdsr_pkg::pdsr_state_e mode,
  input wire logic restart,
  output logic ledOut
);

  localparam logic [31:0] BREATH_P = 32'(BREATH_CYC);
  localparam logic [31:0] MOIST_P = 32'(MOIST_CYC);
  localparam logic [31:0] FAULT_P = 32'(FAULT_CYC);
  localparam logic [31:0] STEP_P = 32'(BREATH_CYC / pdsr_pkg::BREATH_STEPS);

  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] step_reg, step_next;
  logic [8:0] ramp_reg, ramp_next;
  logic led_reg, led_next;
  logic [31:0] period;
  logic [7:0] bright;

  always_comb begin
    case (mode)
      pdsr_pkg::ST_CHARGING: period = BREATH_P;
      pdsr_pkg::ST_MOISTURE: period = MOIST_P;
      pdsr_pkg::ST_FAULT: period = FAULT_P;
      default: period = BREATH_P;
    endcase
    bright = ramp_reg[8] ? ~ramp_reg[7:0] : ramp_reg[7:0];
    // Pattern restarts from its first phase on every state change.
    if (restart || cnt_reg >= period - 32'h1) begin
      cnt_next = 32'h0;
    end else begin
      cnt_next = cnt_reg + 32'h1;
    end
    // The breathing ramp climbs then falls once per period.
    if (restart || step_reg >= STEP_P - 32'h1) begin
      step_next = 32'h0;
    end else begin
      step_next = step_reg + 32'h1;
    end
    if (restart) begin
      ramp_next = 9'h000;
    end else if (step_reg >= STEP_P - 32'h1) begin
      ramp_next = ramp_reg + 9'h001;
    end else begin
      ramp_next = ramp_reg;
    end
    case (mode)
      pdsr_pkg::ST_CHARGING: led_next = cnt_reg[7:0] < bright;
      pdsr_pkg::ST_MISMATCH: led_next = 1'b1;
      pdsr_pkg::ST_MOISTURE: led_next = cnt_reg < (MOIST_P >> 1);
      pdsr_pkg::ST_FAULT: led_next = cnt_reg < (FAULT_P >> 1);
      default: led_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 32'h0;
      step_reg <= 32'h0;
      ramp_reg <= 9'h000;
      led_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      step_reg <= step_next;
      ramp_reg <= ramp_next;
      led_reg <= led_next;
    end
  end

  assign ledOut = led_reg;

endmodule // pdsr_indicator

// ### pdsr_sink_ctrl.sv
// Sink request, power object ranking and status control with Avalon-MM regs.
`timescale 1ns/1ns
module pdsr_sink_ctrl #(
  parameter int BREATH_CYC = pdsr_pkg::BREATH_CYC,
  parameter int MOIST_CYC = pdsr_pkg::MOIST_CYC,
  parameter int FAULT_CYC = pdsr_pkg::FAULT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic [2:0] voltageSelectLevel,
  input wire logic [2:0] currentSelectLevel,
  input wire logic vbusAttached,
  input wire logic rdAttached,
  input wire logic initDone,
  input wire logic ccAttached,
  input wire logic ccOnCc2,
  input wire logic dataLineFault,
  input wire logic overVoltage,
  input wire logic overCurrent,
  input wire logic underVoltage,
  output logic outputSwitchEnable,
  output logic dischargeEnable,
  output logic orientationOut,
  output logic indicatorOut,
  output logic irq
);

  localparam int SYNC_W = 15;

  // Every pin input passes two flip-flops; the select levels are straps
  // and are expected to be static while the engine scans.
  logic [SYNC_W-1:0] pinRaw, syncA_reg, syncB_reg;
  assign pinRaw = {voltageSelectLevel, currentSelectLevel, vbusAttached,
                   rdAttached, initDone, ccAttached, ccOnCc2, dataLineFault,
                   overVoltage, overCurrent, underVoltage};

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : gSync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          syncA_reg[g] <= 1'b0;
          syncB_reg[g] <= 1'b0;
        end else begin
          syncA_reg[g] <= pinRaw[g];
          syncB_reg[g] <= syncA_reg[g];
        end
      end
    end
  endgenerate

  logic [2:0] vLevel, iLevel;
  logic ready, ccIsAttached, ccSecond, moisture, protect;
  assign vLevel = syncB_reg[14:12];
  assign iLevel = syncB_reg[11:9];
  assign ready = syncB_reg[8] & syncB_reg[7] & syncB_reg[6];
  assign ccIsAttached = syncB_reg[5];
  assign ccSecond = syncB_reg[4];
  assign moisture = syncB_reg[3];
  assign protect = syncB_reg[2] | syncB_reg[1] | syncB_reg[0];

  logic [8:0] reqVolt, reqCurr;
  assign reqVolt = pdsr_pkg::voltOfLevel(vLevel);
  assign reqCurr = pdsr_pkg::currOfLevel(iLevel);

  // Bus slave: one wait cycle, read data registered at the first edge.
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic busReq, wrTake, rdTake;
  assign busReq = avsRead | avsWrite;
  assign avsWaitRequest = busReq & ~ack_reg;
  assign wrTake = avsWrite & ack_reg;
  assign rdTake = avsRead & ~ack_reg;
  assign avsReadData = rdata_reg;

  logic evalStart, negAccept, negReject, irqClear, nonPdWr, pdoWr;
  assign evalStart = wrTake && avsAddress == pdsr_pkg::OFS_CTRL &&
                     avsWriteData[pdsr_pkg::CTRL_EVAL_START];
  assign negAccept = wrTake && avsAddress == pdsr_pkg::OFS_CTRL &&
                     avsWriteData[pdsr_pkg::CTRL_NEG_ACCEPT];
  assign negReject = wrTake && avsAddress == pdsr_pkg::OFS_CTRL &&
                     avsWriteData[pdsr_pkg::CTRL_NEG_REJECT];
  assign nonPdWr = wrTake && avsAddress == pdsr_pkg::OFS_CTRL;
  assign irqClear = wrTake && avsAddress == pdsr_pkg::OFS_IRQ_CLEAR;
  assign pdoWr = wrTake && avsAddress >= pdsr_pkg::OFS_PDO_BASE &&
                 avsAddress <= pdsr_pkg::OFS_PDO_LAST &&
                 avsAddress[1:0] == 2'h0;

  // Source power object table written by the protocol firmware.
  logic [31:0] pdoTab_reg [pdsr_pkg::PDO_COUNT];
  logic [31:0] pdoTab_next [pdsr_pkg::PDO_COUNT];
  logic nonPd_reg, nonPd_next;
  localparam int IRQ_W = pdsr_pkg::IRQ_WIDTH;
  logic [IRQ_W-1:0] irqEn_reg, irqEn_next;

  always_comb begin
    pdoTab_next = pdoTab_reg;
    if (pdoWr) begin
      pdoTab_next[avsAddress[4:2]] = avsWriteData;
    end
    nonPd_next = nonPdWr ? avsWriteData[pdsr_pkg::CTRL_NON_PD] : nonPd_reg;
    irqEn_next = irqEn_reg;
    if (wrTake && avsAddress == pdsr_pkg::OFS_IRQ_ENABLE) begin
      irqEn_next = avsWriteData[IRQ_W-1:0];
    end
  end

  // Match engine: scans all objects at one voltage, keeps the best ranked
  // fit, then steps to the next lower voltage only if none fitted.
  pdsr_pkg::pdsr_eng_e eng_reg, eng_next;
  logic [2:0] lvl_reg, lvl_next, idx_reg, idx_next, best_reg, best_next;
  logic [1:0] score_reg, score_next;
  logic found_reg, found_next, matchOk_reg, matchOk_next;
  logic evalDone_reg, evalDone_next;
  logic [8:0] resVolt_reg, resVolt_next;
  logic [31:0] ent;
  logic [8:0] curV, eMin, eMax, eCur;
  logic eAdj, fits, take;
  logic [1:0] eScore;

  always_comb begin
    ent = pdoTab_reg[idx_reg];
    curV = pdsr_pkg::voltOfLevel(lvl_reg);
    eMax = ent[pdsr_pkg::PDO_MAXV_LSB +: 9];
    eMin = ent[pdsr_pkg::PDO_MINV_LSB +: 9];
    eCur = ent[pdsr_pkg::PDO_MAXI_LSB +: 9];
    eAdj = ent[pdsr_pkg::PDO_ADJ_BIT];
    eScore = {ent[pdsr_pkg::PDO_EPR_BIT], eAdj};
    fits = ent[pdsr_pkg::PDO_VALID_BIT] && eCur >= reqCurr &&
           (eAdj ? (eMin <= curV && curV <= eMax) : eMax == curV);
    take = fits && (!found_reg || eScore > score_reg);
    eng_next = eng_reg;
    lvl_next = lvl_reg;
    idx_next = idx_reg;
    best_next = best_reg;
    score_next = score_reg;
    found_next = found_reg;
    matchOk_next = matchOk_reg;
    evalDone_next = evalDone_reg;
    resVolt_next = resVolt_reg;
    case (eng_reg)
      pdsr_pkg::ENG_IDLE, pdsr_pkg::ENG_DONE: begin
        if (evalStart) begin
          evalDone_next = 1'b0;
          matchOk_next = 1'b0;
          found_next = 1'b0;
          idx_next = 3'h0;
          lvl_next = vLevel;
          if (vLevel > pdsr_pkg::VOLTAGE_SELECT_LAST_VALID) begin
            evalDone_next = 1'b1;
            eng_next = pdsr_pkg::ENG_DONE;
          end else begin
            eng_next = pdsr_pkg::ENG_SCAN;
          end
        end
      end
      default: begin
        if (take) begin
          found_next = 1'b1;
          best_next = idx_reg;
          score_next = eScore;
          resVolt_next = curV;
        end
        idx_next = idx_reg + 3'h1;
        if (idx_reg == 3'h7) begin
          if (found_next) begin
            matchOk_next = 1'b1;
            evalDone_next = 1'b1;
            eng_next = pdsr_pkg::ENG_DONE;
          end else if (lvl_reg == 3'h0) begin
            evalDone_next = 1'b1;
            eng_next = pdsr_pkg::ENG_DONE;
          end else begin
            lvl_next = lvl_reg - 3'h1;
          end
        end
      end
    endcase
  end

  // Status machine; detach returns to INIT and beats all else, then protection beats the rest.
  pdsr_pkg::pdsr_state_e st_reg, st_next;
  logic sw_reg, sw_next, dis_reg, dis_next, ori_reg, ori_next;

  always_comb begin
    st_next = st_reg;
    if (!ready) begin
      st_next = pdsr_pkg::ST_INIT;
    end else if (protect) begin
      st_next = pdsr_pkg::ST_FAULT;
    end else begin
      case (st_reg)
        pdsr_pkg::ST_FAULT: st_next = pdsr_pkg::ST_FAULT;
        pdsr_pkg::ST_MOISTURE: begin
          if (!moisture) begin
            st_next = pdsr_pkg::ST_INIT;
          end
        end
        default: begin
          if (moisture) begin
            st_next = pdsr_pkg::ST_MOISTURE;
          end else if (negReject) begin
            st_next = pdsr_pkg::ST_MISMATCH;
          end else if (st_reg == pdsr_pkg::ST_CHARGING) begin
            st_next = pdsr_pkg::ST_CHARGING;
          end else if (nonPd_reg ||
                       (evalDone_reg && matchOk_reg && negAccept)) begin
            st_next = pdsr_pkg::ST_CHARGING;
          end else if (evalDone_reg && !matchOk_reg) begin
            st_next = pdsr_pkg::ST_MISMATCH;
          end
        end
      endcase
    end
    sw_next = st_next == pdsr_pkg::ST_CHARGING;
    dis_next = st_next == pdsr_pkg::ST_FAULT;
    ori_next = ccIsAttached ? ccSecond : ori_reg;
  end

  // Interrupts: entry into each state except INIT plus end of evaluation.
  logic [IRQ_W-1:0] irqSt_reg, irqSt_next, irqEvt;
  logic stChange;
  assign stChange = st_next != st_reg;

  always_comb begin
    irqEvt = '0;
    // A reserved request finishes at once while the old done flag is still
    // set, so the start strobe counts as a fresh completion too.
    irqEvt[pdsr_pkg::IRQ_EVAL_DONE] = evalDone_next &
      (~evalDone_reg | evalStart);
    irqEvt[pdsr_pkg::IRQ_CHARGING] = stChange &&
                                     st_next == pdsr_pkg::ST_CHARGING;
    irqEvt[pdsr_pkg::IRQ_MISMATCH] = stChange &&
                                     st_next == pdsr_pkg::ST_MISMATCH;
    irqEvt[pdsr_pkg::IRQ_MOISTURE] = stChange &&
                                     st_next == pdsr_pkg::ST_MOISTURE;
    irqEvt[pdsr_pkg::IRQ_FAULT] = stChange && st_next == pdsr_pkg::ST_FAULT;
    // A new event wins over a clear in the same cycle.
    irqSt_next = irqSt_reg;
    if (irqClear) begin
      irqSt_next = irqSt_reg & ~avsWriteData[IRQ_W-1:0];
    end
    irqSt_next = irqSt_next | irqEvt;
  end

  // Read data mux.
  always_comb begin
    ack_next = busReq & ~ack_reg;
    rdata_next = rdata_reg;
    if (rdTake) begin
      if (avsAddress == pdsr_pkg::OFS_CTRL) begin
        rdata_next = 32'({nonPd_reg, 2'h0});
      end else if (avsAddress == pdsr_pkg::OFS_STATUS) begin
        rdata_next = 32'({eng_reg == pdsr_pkg::ENG_SCAN, dis_reg, sw_reg,
                          ori_reg, evalDone_reg, matchOk_reg, st_reg});
      end else if (avsAddress == pdsr_pkg::OFS_REQUEST) begin
        rdata_next = 32'({iLevel, vLevel, reqCurr, reqVolt});
      end else if (avsAddress == pdsr_pkg::OFS_RESULT) begin
        rdata_next = 32'({best_reg, resVolt_reg});
      end else if (avsAddress == pdsr_pkg::OFS_IRQ_STATUS) begin
        rdata_next = 32'(irqSt_reg);
      end else if (avsAddress == pdsr_pkg::OFS_IRQ_ENABLE) begin
        rdata_next = 32'(irqEn_reg);
      end else if (avsAddress >= pdsr_pkg::OFS_PDO_BASE &&
                   avsAddress <= pdsr_pkg::OFS_PDO_LAST &&
                   avsAddress[1:0] == 2'h0) begin
        rdata_next = pdoTab_reg[avsAddress[4:2]];
      end else begin
        rdata_next = pdsr_pkg::RESET_ZERO;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      rdata_reg <= pdsr_pkg::RESET_ZERO;
      for (int i = 0; i < pdsr_pkg::PDO_COUNT; i++) begin
        pdoTab_reg[i] <= pdsr_pkg::RESET_ZERO;
      end
      nonPd_reg <= 1'b0;
      irqEn_reg <= '0;
      irqSt_reg <= '0;
      eng_reg <= pdsr_pkg::ENG_IDLE;
      lvl_reg <= 3'h0;
      idx_reg <= 3'h0;
      best_reg <= 3'h0;
      score_reg <= 2'h0;
      found_reg <= 1'b0;
      matchOk_reg <= 1'b0;
      evalDone_reg <= 1'b0;
      resVolt_reg <= 9'h000;
      st_reg <= pdsr_pkg::ST_INIT;
      sw_reg <= 1'b0;
      dis_reg <= 1'b0;
      ori_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      pdoTab_reg <= pdoTab_next;
      nonPd_reg <= nonPd_next;
      irqEn_reg <= irqEn_next;
      irqSt_reg <= irqSt_next;
      eng_reg <= eng_next;
      lvl_reg <= lvl_next;
      idx_reg <= idx_next;
      best_reg <= best_next;
      score_reg <= score_next;
      found_reg <= found_next;
      matchOk_reg <= matchOk_next;
      evalDone_reg <= evalDone_next;
      resVolt_reg <= resVolt_next;
      st_reg <= st_next;
      sw_reg <= sw_next;
      dis_reg <= dis_next;
      ori_reg <= ori_next;
    end
  end

  assign outputSwitchEnable = sw_reg;
  assign dischargeEnable = dis_reg;
  assign orientationOut = ori_reg;
  assign irq = |(irqSt_reg & irqEn_reg);

  // Restart rides on the registered state change, so the pattern restarts
  // one cycle after the state begins.
  logic stPrevChange_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stPrevChange_reg <= 1'b0;
    end else begin
      stPrevChange_reg <= stChange;
    end
  end

  pdsr_indicator #(
    .BREATH_CYC(BREATH_CYC),
    .MOIST_CYC(MOIST_CYC),
    .FAULT_CYC(FAULT_CYC)
  ) uIndicator (
    .clk(clk),
    .nrst(nrst),
    .mode(st_reg),
    .restart(stPrevChange_reg),
    .ledOut(indicatorOut)
  );

endmodule // pdsr_sink_ctrl

// ### pdsr_sink_ctrl_asserts.sv
// Port-level assertions of the sink control block.
`timescale 1ns/1ns
module pdsr_sink_ctrl_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitRequest,
  input wire logic vbusAttached,
  input wire logic rdAttached,
  input wire logic initDone,
  input wire logic ccAttached,
  input wire logic ccOnCc2,
  input wire logic dataLineFault,
  input wire logic overVoltage,
  input wire logic outputSwitchEnable,
  input wire logic dischargeEnable,
  input wire logic orientationOut,
  input wire logic indicatorOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic ready;
  assign ready = vbusAttached && rdAttached && initDone;
  // Pin inputs pass two sync stages, so the state windows span three samples and the indicator window six.
  sequence sLost;
    !ready [*3];
  endsequence
  sequence sDark;
    !ready [*6];
  endsequence
  sequence sHot(logic ev);
    (ready && ev) [*3];
  endsequence
  chk_init_open: assert property (sLost |-> ##1 !outputSwitchEnable)
    else $error("output switch closed while not ready");
  chk_init_dark: assert property (sDark |-> ##1 !indicatorOut)
    else $error("indicator lit while not ready");
  chk_fault_drain: assert property (sHot(overVoltage) |-> ##1
    (dischargeEnable && !outputSwitchEnable))
    else $error("protection event did not open and discharge");
  chk_moist_open: assert property (sHot(dataLineFault) |->
    ##1 !outputSwitchEnable)
    else $error("output switch closed during moisture");
  chk_flip_low: assert property ((ccAttached && !ccOnCc2) [*3] |->
    ##1 !orientationOut)
    else $error("orientation not low for first channel");
  chk_flip_high: assert property ((ccAttached && ccOnCc2) [*3] |->
    ##1 orientationOut)
    else $error("orientation not high for second channel");
  chk_switch_excl: assert property (
    !(outputSwitchEnable && dischargeEnable))
    else $error("switch closed while discharging");
  chk_wait_first: assert property ($rose(avsRead || avsWrite) |->
    avsWaitRequest)
    else $error("bus answered in the first request cycle");
  chk_wait_bound: assert property ((avsRead || avsWrite) |->
    ##[0:1] !avsWaitRequest)
    else $error("bus answer late");
endmodule // pdsr_sink_ctrl_chk

bind pdsr_sink_ctrl pdsr_sink_ctrl_chk pdsr_sink_ctrl_chk_i (
  .clk(clk), .nrst(nrst), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsWaitRequest(avsWaitRequest), .vbusAttached(vbusAttached),
  .rdAttached(rdAttached), .initDone(initDone), .ccAttached(ccAttached),
  .ccOnCc2(ccOnCc2), .dataLineFault(dataLineFault),
  .overVoltage(overVoltage), .outputSwitchEnable(outputSwitchEnable),
  .dischargeEnable(dischargeEnable), .orientationOut(orientationOut),
  .indicatorOut(indicatorOut)
);

// ### pdsr_source_model.sv
// Behavioural model of the charger's power source across the link.
`timescale 1ns/1ns
module pdsr_source_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic plugIn,
  input wire logic switchOn,
  input wire logic negFail,
  input wire logic [8:0] reqVolt,
  output logic vbusAttached,
  output logic [8:0] vbusVolt
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vbusAttached <= 1'h0;
      vbusVolt <= 9'h000;
    end else begin
      vbusAttached <= plugIn;
      if (!plugIn) begin
        vbusVolt <= 9'h000;
      end else if (switchOn && !negFail) begin
        vbusVolt <= reqVolt;
      end else begin
        vbusVolt <= 9'h032;
      end
    end
  end
endmodule // pdsr_source_model

// ### pd_sink_request_and_status_tb_top.sv
// Self-checking bench of the sink control block.
`timescale 1ns/1ns
module pd_sink_request_and_status_tb_top;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] avsAddress = 8'h00;
  logic avsRead = 1'h0;
  logic avsWrite = 1'h0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic [2:0] vLvl = 3'h0;
  logic [2:0] iLvl = 3'h0;
  logic plugIn = 1'h0;
  logic negFail = 1'h0;
  logic rdAttached = 1'h0;
  logic initDone = 1'h0;
  logic ccAttached = 1'h0;
  logic ccOnCc2 = 1'h0;
  logic dataLineFault = 1'h0;
  logic overVoltage = 1'h0;
  logic overCurrent = 1'h0;
  logic underVoltage = 1'h0;
  logic vbusAttached, outputSwitchEnable, dischargeEnable;
  logic orientationOut, indicatorOut, irq;
  logic [8:0] vbusVolt;
  logic [31:0] d;
  logic [31:0] r;
  logic [31:0] seed = 32'h0001_4971;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int h;

  pdsr_sink_ctrl #(.BREATH_CYC(4096), .MOIST_CYC(2048), .FAULT_CYC(600))
  pdsr_sink_ctrl_i (.clk(clk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .voltageSelectLevel(vLvl), .currentSelectLevel(iLvl),
    .vbusAttached(vbusAttached), .rdAttached(rdAttached),
    .initDone(initDone), .ccAttached(ccAttached), .ccOnCc2(ccOnCc2),
    .dataLineFault(dataLineFault), .overVoltage(overVoltage),
    .overCurrent(overCurrent), .underVoltage(underVoltage),
    .outputSwitchEnable(outputSwitchEnable),
    .dischargeEnable(dischargeEnable), .orientationOut(orientationOut),
    .indicatorOut(indicatorOut), .irq(irq));
  pdsr_source_model pdsr_source_model_i (.clk(clk), .nrst(nrst),
    .plugIn(plugIn), .switchOn(outputSwitchEnable), .negFail(negFail),
    .reqVolt(9'h096), .vbusAttached(vbusAttached), .vbusVolt(vbusVolt));

  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [8:0] expV(input logic [2:0] l);
    logic [8:0] t [8] = '{9'h032, 9'h05A, 9'h078, 9'h096, 9'h0C8, 9'h118,
      9'h000, 9'h000};
    return t[l];
  endfunction
  function automatic logic [8:0] expI(input logic [2:0] l);
    logic [8:0] t [8] = '{9'h064, 9'h096, 9'h0C8, 9'h0FA, 9'h12C, 9'h15E,
      9'h190, 9'h1F4};
    return t[l];
  endfunction
  function automatic logic [31:0] pdo(input logic e, input logic a,
      input logic [8:0] lo, input logic [8:0] hi, input logic [8:0] cur);
    return {1'h1, 2'h0, e, a, lo, hi, cur};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] w);
    int n;
    n = 0;
    avsAddress <= a;
    avsWriteData <= w;
    avsWrite <= wr;
    avsRead <= !wr;
    @(posedge clk);
    while (avsWaitRequest !== 1'h0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    err_total += int'(n == 50);
    d = avsReadData;
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
    @(posedge clk);
  endtask
  task automatic stateIs(input logic [2:0] s);
    bus(1'h0, pdsr_pkg::OFS_STATUS, 32'h0);
    check(32'(d[2:0]), 32'(s));
  endtask
  task automatic resIs(input logic [31:0] e);
    bus(1'h0, pdsr_pkg::OFS_RESULT, 32'h0);
    check(d & 32'h0000_0FFF, e);
  endtask
  task automatic plug(input logic on);
    plugIn <= on;
    rdAttached <= on;
    initDone <= on;
    repeat (8) @(posedge clk);
  endtask
  task automatic loadTab(input logic [31:0] a, b, c);
    for (int k = 0; k < 8; k++) begin
      bus(1'h1, pdsr_pkg::OFS_PDO_BASE + 8'(4 * k),
        k == 0 ? a : k == 1 ? b : k == 2 ? c : 32'h0);
    end
  endtask
  task automatic evalRun(input logic [2:0] v, input logic [2:0] i);
    int n;
    n = 0;
    vLvl <= v;
    iLvl <= i;
    repeat (5) @(posedge clk);
    bus(1'h1, pdsr_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
    bus(1'h1, pdsr_pkg::OFS_CTRL, 32'h0000_0001);
    d = 32'h0;
    while (d[0] !== 1'h1 && n < 40) begin
      bus(1'h0, pdsr_pkg::OFS_IRQ_STATUS, 32'h0);
      n++;
    end
    check(32'(d[0]), 32'h1);
    repeat (2) @(posedge clk);
  endtask
  task automatic countHigh(input int n);
    h = 0;
    repeat (n) begin
      @(posedge clk);
      h += (indicatorOut === 1'h1);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    stateIs(3'h0);
    bus(1'h0, 8'h30, 32'h0);
    check(d, 32'h0);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      vLvl <= k[2:0];
      iLvl <= r[2:0];
      ccAttached <= 1'h1;
      ccOnCc2 <= r[3];
      repeat (5) @(posedge clk);
      bus(1'h0, pdsr_pkg::OFS_REQUEST, 32'h0);
      check(32'(d[8:0]), 32'(expV(k[2:0])));
      check(32'(d[17:9]), 32'(expI(r[2:0])));
      check(32'(orientationOut), 32'(r[3]));
    end
    plug(1'h1);
    bus(1'h1, pdsr_pkg::OFS_IRQ_ENABLE, 32'h0000_0002);
    loadTab(pdo(1'h0, 1'h0, 9'h0, 9'h0C8, 9'h12C),
      pdo(1'h0, 1'h1, 9'h021, 9'h0D2, 9'h12C),
      pdo(1'h1, 1'h0, 9'h0, 9'h0C8, 9'h12C));
    evalRun(3'h4, 3'h2);
    check(32'(irq), 32'h0);
    resIs(32'h0000_04C8);
    bus(1'h1, pdsr_pkg::OFS_PDO_BASE + 8'h08, 32'h0);
    evalRun(3'h4, 3'h2);
    resIs(32'h0000_02C8);
    loadTab(pdo(1'h0, 1'h0, 9'h0, 9'h118, 9'h096),
      pdo(1'h0, 1'h0, 9'h0, 9'h096, 9'h0C8),
      pdo(1'h0, 1'h0, 9'h0, 9'h078, 9'h0FA));
    evalRun(3'h5, 3'h2);
    resIs(32'h0000_0296);
    bus(1'h1, pdsr_pkg::OFS_CTRL, 32'h0000_0002);
    repeat (2) @(posedge clk);
    stateIs(3'h1);
    check(32'(outputSwitchEnable), 32'h1);
    check(32'(irq), 32'h1);
    check(32'(vbusVolt), 32'h96);
    countHigh(4096);
    check(32'(h > 0 && h < 4096), 32'h1);
    bus(1'h1, pdsr_pkg::OFS_IRQ_CLEAR, 32'h0000_0002);
    check(32'(irq), 32'h0);
    plug(1'h0);
    bus(1'h1, pdsr_pkg::OFS_CTRL, 32'h0000_0004);
    for (int j = 0; j < 3; j++) begin
      plug(1'h1);
      stateIs(3'h1);
      {underVoltage, overCurrent, overVoltage} <= 3'(1 << j);
      repeat (6) @(posedge clk);
      {underVoltage, overCurrent, overVoltage} <= 3'h0;
      stateIs(3'h4);
      check(32'({outputSwitchEnable, dischargeEnable}), 32'h1);
      if (j == 0) begin
        countHigh(600);
        check(32'(h), 32'h12C);
      end
      plug(1'h0);
      stateIs(3'h0);
      check(32'({outputSwitchEnable, indicatorOut}), 32'h0);
    end
    plug(1'h1);
    dataLineFault <= 1'h1;
    repeat (6) @(posedge clk);
    stateIs(3'h3);
    check(32'(outputSwitchEnable), 32'h0);
    countHigh(2048);
    check(32'(h), 32'h400);
    bus(1'h1, pdsr_pkg::OFS_CTRL, 32'h0);
    dataLineFault <= 1'h0;
    repeat (6) @(posedge clk);
    stateIs(3'h0);
    negFail <= 1'h1;
    evalRun(3'h5, 3'h5);
    stateIs(3'h2);
    check(32'({outputSwitchEnable, vbusVolt}), 32'h032);
    countHigh(64);
    check(32'(h), 32'h40);
    plug(1'h0);
    plug(1'h1);
    evalRun(3'h6, 3'h0);
    stateIs(3'h2);
    check(32'(d[4:3]), 32'h2);
    check(32'(outputSwitchEnable), 32'h0);
    wrap_up();
  end
endmodule // pd_sink_request_and_status_tb_top
